// >>> test/banked_cpu_register_set_control_tb.sv
// Self-checking bench for the banked register set block
`timescale 1ns/1ps
`include "bcr_defines.vh"
module banked_cpu_register_set_control_tb;
    // Inputs driven by the bench
    reg         pclk, presetn, psel, penable, pwrite, ext_clk, nmi_take, bidir_irq_pin_ext_n, host_go;
    reg  [11:0] paddr;
    reg  [31:0] pwdata;
    reg  [7:0]  xcvr_status, vec_low, host_val;
    reg  [4:0]  irq_req, ct, xt;
    // Design outputs
    wire [31:0] prdata;
    wire        pready, pslverr, acc_wr, cpu_tick, xcvr_tick, clk_oe, bidir_irq_pin_o, bidir_irq_pin_oe, host_wr;
    wire [1:0]  acc_idx, iws;
    wire [2:0]  dws;
    wire [4:0]  irq_act;
    wire [7:0]  acc_data, host_wdata, host_reg;
    wire [15:0] vec_addr;
    // Pin level: design drives it when enabled, otherwise the bench side
    wire        bidir_irq_pin_pin = bidir_irq_pin_oe ? bidir_irq_pin_o : bidir_irq_pin_ext_n;
    integer     error_cnt, checks_done, cyc, i;
    // Expected R20 per operation code 0..5 with R5=03 and R8=10
    wire [47:0] exp_ops = 48'h1313_00f3_1303;

    bcr_regset uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .xcvr_status(xcvr_status), .xcvr_acc_wr_q(acc_wr), .xcvr_acc_idx_q(acc_idx),
        .xcvr_acc_data_q(acc_data), .ext_xcvr_clock_in(ext_clk), .cpu_tick_q(cpu_tick),
        .xcvr_tick_q(xcvr_tick), .clock_out_oe_q(clk_oe), .instr_wait_select_q(iws),
        .data_wait_select_q(dws), .irq_req(irq_req), .vec_low(vec_low), .nmi_take(nmi_take),
        .irq_active_q(irq_act), .vector_addr_q(vec_addr), .bidir_irq_n_i(bidir_irq_pin_pin),
        .bidir_irq_n_o(bidir_irq_pin_o), .bidir_irq_n_oe(bidir_irq_pin_oe), .host_wr(host_wr),
        .host_wdata(host_wdata), .host_side_control_reg_q(host_reg));

    bcr_host_model host (.pclk(pclk), .presetn(presetn), .go(host_go), .val(host_val),
        .host_wr(host_wr), .host_wdata(host_wdata));

    always #50 pclk = ~pclk;

    // Watchdog: the whole sequence needs well under this many cycles
    always @(posedge pclk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin
            error_cnt = error_cnt + 1;
            print_verdict;
        end
    end

    task print_verdict;
        begin
            if (error_cnt == 0 && checks_done > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    task chk(input [31:0] seen, input [31:0] want);
        begin
            checks_done = checks_done + 1;
            if (seen !== want) begin
                error_cnt = error_cnt + 1;
                $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
            end
        end
    endtask

    // One APB transfer; waits for pready under a bound, checks data and error
    task xfer(input w, input [11:0] a, input [15:0] d, input [7:0] e, input er);
        integer n;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= {16'h0000, d};
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && n < 20) begin
                @(posedge pclk);
                n = n + 1;
            end
            if (n == 20) error_cnt = error_cnt + 1;
            psel <= 1'b0;
            penable <= 1'b0;
            if (!w && !er) chk(prdata, {24'h0, e});
            chk({31'h0, pslverr}, {31'h0, er});
        end
    endtask

    // Let register updates reach the outputs
    task nap;
        repeat (3) @(posedge pclk);
    endtask

    // Count ticks over 16 cycles while the external clock makes four rising edges
    task ticks;
        integer k;
        begin
            nap;
            ct = 0;
            xt = 0;
            for (k = 0; k < 16; k = k + 1) begin
                @(posedge pclk);
                if (k < 8) ext_clk <= ~ext_clk;
                ct = ct + cpu_tick;
                xt = xt + xcvr_tick;
            end
        end
    endtask

    initial begin
        {pclk, presetn, psel, penable, pwrite, ext_clk, nmi_take, host_go} = 8'h00;
        {paddr, pwdata, vec_low, host_val, irq_req} = 0;
        xcvr_status = 8'hc3;
        bidir_irq_pin_ext_n = 1'b1;
        {error_cnt, checks_done, cyc} = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        // Reset state
        xfer(0, `BCR_BANK_OFS, 0, 8'h03, 0);
        xfer(0, 12'h000, 0, 8'h1f, 0);
        chk({27'h0, iws, dws}, 32'h1f);
        xfer(0, 12'h004, 0, 8'h00, 0);
        nmi_take <= 1'b1;
        nap;
        chk({16'h0, vec_addr}, 32'h001c);
        xfer(1, 12'h004, 16'h00a5, 0, 0);
        nmi_take <= 1'b0;
        vec_low <= 8'h33;
        nap;
        chk({16'h0, vec_addr}, 32'ha533);
        // Refused accesses
        xfer(0, `BCR_EXCH_OFS, 0, 0, 1);
        xfer(1, `BCR_BANK_OFS, 0, 0, 1);
        xfer(1, 12'h030, 16'h0011, 0, 1);
        // Every transceiver source, then the halved CPU clock; software aims at eight times the bit rate
        for (i = 0; i < 4; i = i + 1) begin
            xfer(1, 12'h000, {8'h00, 1'b0, i[1:0], 5'h0a}, 0, 0);
            ticks;
            chk(ct, 16);
            chk(xt, (i == 3) ? 4 : 16 >> i);
            chk({27'h0, iws, dws}, 32'h0a);
        end
        xfer(1, 12'h000, 16'h0080, 0, 0);
        ticks;
        chk(ct, 8);
        // Exchange to both main banks, then use them at once
        xfer(1, `BCR_EXCH_OFS, 16'h000c, 0, 0);
        xfer(1, 12'h020, 16'h0010, 0, 0);
        xfer(0, 12'h000, 0, 8'h04, 0);
        xfer(1, 12'h014, 16'h0003, 0, 0);
        for (i = 0; i < 6; i = i + 1) begin
            xfer(1, `BCR_ALU_OFS, {3'b000, i[2:0], 10'h285}, 0, 0);
            xfer(0, 12'h050, 0, exp_ops[8*i +: 8], 0);
        end
        xfer(0, 12'h020, 0, 8'h10, 0);
        xfer(1, `BCR_ALU_OFS, 16'h0505, 0, 0);
        xfer(0, 12'h020, 0, 8'h13, 0);
        xfer(1, 12'h06c, 16'h0099, 0, 0);
        // Alternate B only: own accumulator and transceiver access
        xfer(1, `BCR_EXCH_OFS, 16'h0002, 0, 0);
        xfer(0, `BCR_BANK_OFS, 0, 8'h02, 0);
        xfer(1, 12'h020, 16'h0077, 0, 0);
        xfer(1, 12'h018, 16'h005c, 0, 0);
        @(posedge pclk);
        chk({21'h0, acc_wr, acc_idx, acc_data}, 32'h65c);
        xfer(0, 12'h06c, 0, 8'h99, 0);
        xfer(1, `BCR_EXCH_OFS, 16'h0000, 0, 0);
        xfer(0, 12'h020, 0, 8'h13, 0);
        // Immediate writes
        xfer(1, `BCR_IMM_OFS, 16'h0442, 0, 0);
        xfer(0, 12'h010, 0, 8'h42, 0);
        xfer(1, `BCR_IMM_OFS, 16'h1042, 0, 1);
        xfer(1, `BCR_IMM_OFS, 16'h1442, 0, 1);
        // Main A: status, masks, aux control
        xfer(0, 12'h004, 0, 8'hc3, 0);
        xfer(1, 12'h000, 16'h0001, 0, 1);
        irq_req <= 5'h01;
        xfer(1, 12'h008, 16'h0001, 0, 0);
        xfer(1, 12'h00c, 16'h0001, 0, 0);
        nap;
        chk(irq_act, 5'h01);
        xfer(1, 12'h00c, 16'h0002, 0, 0);
        nap;
        chk(irq_act, 5'h00);
        chk({bidir_irq_pin_oe, bidir_irq_pin_pin}, 2'b11);
        xfer(1, 12'h008, 16'h0008, 0, 0);
        nap;
        chk({bidir_irq_pin_oe, bidir_irq_pin_pin}, 2'b10);
        bidir_irq_pin_ext_n <= 1'b0;
        xfer(1, 12'h00c, 16'h0001, 0, 0);
        nap;
        chk(irq_act, 5'h08);
        chk(clk_oe, 1);
        xfer(1, 12'h00c, 16'h0004, 0, 0);
        nap;
        chk(clk_oe, 0);
        // Host write alongside a local access
        host_val <= 8'h5a;
        host_go <= 1'b1;
        xfer(0, `BCR_BANK_OFS, 0, 8'h00, 0);
        chk(host_reg, 8'h5a);
        // Second reset restores the alternate banks
        presetn <= 1'b0;
        nap;
        presetn <= 1'b1;
        xfer(0, `BCR_BANK_OFS, 0, 8'h03, 0);
        print_verdict;
    end
endmodule

// >>> test/bcr_host_model.sv
// Remote host model that loads the host-only control register
`timescale 1ns/1ps
module bcr_host_model (
    // Clock and reset
    input wire       pclk,
    input wire       presetn,
    // Bench command: rising level requests one write
    input wire       go,
    input wire [7:0] val,
    // Host control write port
    output reg       host_wr,
    output reg [7:0] host_wdata
);
    reg go_q; // Last command level, for edge detect

    // Host writes run on their own port, never through local register access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            go_q <= 1'b0;
            host_wr <= 1'b0;
            host_wdata <= 8'h00;
        end else begin
            go_q <= go;
            host_wr <= go && !go_q;
            // Data only means something with the strobe, so scramble it otherwise
            host_wdata <= (go && !go_q) ? val : ~host_wdata;
        end
    end
endmodule

// >>> test/bcr_regset_properties.sv
// Port checker for the banked register set block
`timescale 1ns/1ps
module bcr_regset_properties (
    // Clock, reset and APB
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire        pready,
    input wire        pslverr,
    // Control outputs and their causes
    input wire        xcvr_acc_wr_q,
    input wire [1:0]  instr_wait_select_q,
    input wire [2:0]  data_wait_select_q,
    input wire [4:0]  irq_req,
    input wire [7:0]  vec_low,
    input wire        nmi_take,
    input wire [4:0]  irq_active_q,
    input wire [15:0] vector_addr_q,
    input wire        bidir_irq_n_i,
    input wire        bidir_irq_n_oe,
    // Host side
    input wire        host_wr,
    input wire [7:0]  host_wdata,
    input wire [7:0]  host_side_control_reg_q
);
    // Single clock domain, so one default serves every property
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    rdy_pulse_a: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    rdy_norm_a: assert property (psel && penable && !pready && !$past(penable) && paddr != 12'h080
        |=> pready) else $error("access not answered next cycle");
    exch_lat_a: assert property (psel && penable && pwrite && !pready && !$past(penable) && paddr == 12'h080
        |=> !pready ##1 pready) else $error("exchange not two cycles");
    err_qual_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    acc_pulse_a: assert property (xcvr_acc_wr_q |-> $past(pready && pwrite && paddr[11:4] == 8'h01))
        else $error("transceiver write pulse without cause");
    vec_low_a: assert property ($past(presetn) |->
        vector_addr_q[7:0] == $past(nmi_take ? 8'h1c : vec_low)) else $error("vector low byte wrong");
    irq_gate_a: assert property ($past(presetn) |-> (irq_active_q & 5'h17 & ~$past(irq_req)) == 5'h00)
        else $error("interrupt active without request");
    bidir_irq_pin_in_a: assert property (irq_active_q[3] |-> $past(!bidir_irq_n_oe && !bidir_irq_n_i))
        else $error("pin interrupt while driving or idle");
    host_set_a: assert property (host_wr |=> host_side_control_reg_q == $past(host_wdata))
        else $error("host register not loaded");
    wait_rst_a: assert property (!$past(presetn) |-> instr_wait_select_q == 2'd3 && data_wait_select_q == 3'd7)
        else $error("wait fields not at maximum after reset");
endmodule

bind bcr_regset bcr_regset_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready,
    .pslverr, .xcvr_acc_wr_q, .instr_wait_select_q, .data_wait_select_q, .irq_req, .vec_low, .nmi_take,
    .irq_active_q, .vector_addr_q, .bidir_irq_n_i, .bidir_irq_n_oe, .host_wr, .host_wdata,
    .host_side_control_reg_q);

// >>> verilog/bcr_clk_ctl.v
// Clock select, tick generation and clock output enable
`timescale 1ns/1ps
module bcr_clk_ctl (
    // Clock and reset
    input  wire       pclk,
    input  wire       presetn,
    // Selections
    input  wire       cpu_clock_select,
    input  wire [1:0] xcvr_clock_select,
    input  wire       clock_out_disable,
    input  wire       ext_xcvr_clock_in,
    // Results
    output reg        cpu_tick_q,
    output reg        xcvr_tick_q,
    output reg        clock_out_oe_q
);
    reg [1:0] div_q;      // Oscillator divider
    reg       ext_prev_q; // Last sample of external clock
    reg       xtick_d;    // Next transceiver tick

    // Free-running divider of the oscillator (pclk)
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q      <= 2'h0;
            ext_prev_q <= 1'b0;
        end else begin
            div_q      <= div_q + 2'h1;
            ext_prev_q <= ext_xcvr_clock_in;
        end
    end

    // Transceiver tick source choice
    always @* begin
        case (xcvr_clock_select)
            2'h0:    xtick_d = 1'b1;
            2'h1:    xtick_d = div_q[0];
            2'h2:    xtick_d = (div_q == 2'h3);
            2'h3:    xtick_d = ext_xcvr_clock_in & ~ext_prev_q;
            default: xtick_d = 1'b0;
        endcase
    end

    // Registered ticks; clock output enable ignores cpu divide
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_tick_q     <= 1'b0;
            xcvr_tick_q    <= 1'b0;
            clock_out_oe_q <= 1'b0;
        end else begin
            cpu_tick_q     <= cpu_clock_select ? div_q[0] : 1'b1;
            xcvr_tick_q    <= xtick_d;
            clock_out_oe_q <= ~clock_out_disable;
        end
    end
endmodule

// >>> verilog/bcr_defines.vh
// Constants for the banked register set control block
`ifndef BCR_DEFINES_VH
`define BCR_DEFINES_VH

// APB byte offsets; locations R0..R31 sit at 4 * location number
`define BCR_LOC_BASE      12'h000
`define BCR_EXCH_OFS      12'h080
`define BCR_IMM_OFS       12'h084
`define BCR_ALU_OFS       12'h088
`define BCR_BANK_OFS      12'h08c

// Register locations
`define BCR_LOC_R0        5'h00
`define BCR_LOC_R1        5'h01
`define BCR_LOC_R2        5'h02
`define BCR_LOC_R3        5'h03
`define BCR_LOC_R4        5'h04
`define BCR_LOC_R8        5'h08
`define BCR_LOC_R11       5'h0b
`define BCR_LOC_R20       5'h14
`define BCR_LOC_R27       5'h1b
`define BCR_IMM_LIMIT     5'h10

// Device control register fields
`define BCR_DCR_CCS       7
`define BCR_DCR_TCS_HI    6
`define BCR_DCR_TCS_LO    5
`define BCR_DCR_IW_HI     4
`define BCR_DCR_IW_LO     3
`define BCR_DCR_DW_HI     2
`define BCR_DCR_DW_LO     0
`define BCR_DCR_RESET     8'h1f

// Aux control register fields
`define BCR_ACR_GIE       0
`define BCR_ACR_BIC       1
`define BCR_ACR_COD       2
`define BCR_ACR_RESET     8'h00

// Interrupt masks, vector base, host control
`define BCR_IRQ_THREE     3
`define BCR_IMR_RESET     8'h00
`define BCR_VBR_RESET     8'h00
`define BCR_NMI_VEC_LOW   8'h1c
`define BCR_HOST_RESET    8'h00

// Exchange command bits
`define BCR_EX_ALT_A      0
`define BCR_EX_ALT_B      1
`define BCR_EX_IRQ_CHG    2
`define BCR_EX_IRQ_VAL    3
`define BCR_EXCH_CYCLES   2'd2

// ALU operation codes
`define BCR_OP_MOV        3'h0
`define BCR_OP_ADD        3'h1
`define BCR_OP_SUB        3'h2
`define BCR_OP_AND        3'h3
`define BCR_OP_OR         3'h4
`define BCR_OP_XOR        3'h5

`endif

// >>> verilog/bcr_regset.v
// Banked CPU register set with APB access and control outputs
//
// How it works
// - Five-bit location field, thirty-two locations
// - R0-R11 split into banked groups A, B
// - Exchange picks group A and B independently
// - Immediate writes reach only R0-R15
// - General storage in B banks and R20-R27
// - Bank contents: control, config, general, transceiver
// - R8 accumulator is second operand
// - Reset selects alternate bank for both
// - Exchange is two cycles, optional interrupt enable
// - Two-bit transceiver clock source select
// - CPU clock oscillator or half of it
// - Clock output always undivided oscillator
// - Clock out disable floats the pin
// - Wait-state fields in device control register
// - Wait fields reset to three and seven
// - Vector base gives vector high byte
// - Vector base resets zero, NMI at 001Ch
// - Per-interrupt masks gated by global enable
// - Direction bit; mask three masks or drives
// - Host control register reachable only by host
// - Host access never stalls local register access
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "bcr_defines.vh"
module bcr_regset (
    // APB slave
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Transceiver status and access
    input  wire [7:0]  xcvr_status,
    output reg         xcvr_acc_wr_q,
    output reg  [1:0]  xcvr_acc_idx_q,
    output reg  [7:0]  xcvr_acc_data_q,
    // Timing control
    input  wire        ext_xcvr_clock_in,
    output wire        cpu_tick_q,
    output wire        xcvr_tick_q,
    output wire        clock_out_oe_q,
    output reg  [1:0]  instr_wait_select_q,
    output reg  [2:0]  data_wait_select_q,
    // Interrupts
    input  wire [4:0]  irq_req,
    input  wire [7:0]  vec_low,
    input  wire        nmi_take,
    output reg  [4:0]  irq_active_q,
    output reg  [15:0] vector_addr_q,
    input  wire        bidir_irq_n_i,
    output reg         bidir_irq_n_o,
    output reg         bidir_irq_n_oe,
    // Remote host
    input  wire        host_wr,
    input  wire [7:0]  host_wdata,
    output reg  [7:0]  host_side_control_reg_q
);
    // Bank selects, one for each group
    reg        alt_a_q;
    reg        alt_b_q;
    // Control and configuration registers
    reg [7:0]  device_control_reg_q;
    reg [7:0]  aux_control_reg_q;
    reg [7:0]  irq_mask_reg_q;
    reg [7:0]  vector_base_reg_q;
    reg [7:0]  cfg_a_q [0:1];   // Alternate A R2, R3
    // General storage and transceiver access registers
    reg [7:0]  main_b_q [0:7];  // Main B R4..R11
    reg [7:0]  alt_b_q_mem [0:3]; // Alternate B R8..R11
    reg [7:0]  xacc_q [0:3];    // Alternate B R4..R7
    reg [7:0]  gen_hi_q [0:7];  // R20..R27
    // Bus handling
    reg [1:0]  wait_cnt_q;      // Exchange access cycle counter
    reg [31:0] rd_d;
    reg        err_d;
    reg        wr_en;
    reg [4:0]  wr_loc;
    reg [7:0]  wr_val;
    reg [7:0]  alu_res;
    integer    i;

    wire       setup_ok  = psel & penable & ~pready;
    wire       commit    = psel & penable & pready;
    wire       is_loc    = (paddr[11:7] == 5'h00) && (paddr[1:0] == 2'h0);
    wire [4:0] loc       = paddr[6:2];
    wire       is_exch   = (paddr == `BCR_EXCH_OFS);
    wire       is_imm    = (paddr == `BCR_IMM_OFS);
    wire       is_alu    = (paddr == `BCR_ALU_OFS);
    wire       is_bank   = (paddr == `BCR_BANK_OFS);
    wire [4:0] imm_loc   = pwdata[12:8];
    wire [4:0] alu_src   = pwdata[4:0];
    wire [4:0] alu_dst   = pwdata[9:5];
    wire [2:0] alu_op    = pwdata[12:10];
    wire       pin_input = ~aux_control_reg_q[`BCR_ACR_BIC];
    wire       global_irq_enable       = aux_control_reg_q[`BCR_ACR_GIE];

    // Read one location through the current bank mapping
    function [7:0] rd_loc;
        input [4:0] a;
        begin
            rd_loc = 8'h00;
            if (a <= `BCR_LOC_R3) begin
                if (alt_a_q) begin
                    case (a[1:0])
                        2'h0:    rd_loc = device_control_reg_q;
                        2'h1:    rd_loc = vector_base_reg_q;
                        default: rd_loc = cfg_a_q[a[0]];
                    endcase
                end else begin
                    case (a[1:0])
                        2'h0:    rd_loc = {4'h0, ~bidir_irq_n_i, global_irq_enable, alt_b_q, alt_a_q};
                        2'h1:    rd_loc = xcvr_status;
                        2'h2:    rd_loc = irq_mask_reg_q;
                        default: rd_loc = aux_control_reg_q;
                    endcase
                end
            end else if (a <= `BCR_LOC_R11) begin
                if (!alt_b_q)
                    rd_loc = main_b_q[a[2:0] - 3'h4];
                else if (a < `BCR_LOC_R8)
                    rd_loc = xacc_q[a[1:0]];
                else
                    rd_loc = alt_b_q_mem[a[1:0]];
            end else if ((a >= `BCR_LOC_R20) && (a <= `BCR_LOC_R27)) begin
                rd_loc = gen_hi_q[a[2:0] - 3'h4];
            end
        end
    endfunction

    // Location writable by software from this side
    function loc_ok;
        input [4:0] a;
        begin
            loc_ok = ((a <= `BCR_LOC_R11) && !(!alt_a_q && (a <= `BCR_LOC_R1)))
                   || ((a >= `BCR_LOC_R20) && (a <= `BCR_LOC_R27));
        end
    endfunction

    // Two-operand result with the visible accumulator
    always @* begin
        case (alu_op)
            `BCR_OP_MOV: alu_res = rd_loc(alu_src);
            `BCR_OP_ADD: alu_res = rd_loc(alu_src) + rd_loc(`BCR_LOC_R8);
            `BCR_OP_SUB: alu_res = rd_loc(alu_src) - rd_loc(`BCR_LOC_R8);
            `BCR_OP_AND: alu_res = rd_loc(alu_src) & rd_loc(`BCR_LOC_R8);
            `BCR_OP_OR:  alu_res = rd_loc(alu_src) | rd_loc(`BCR_LOC_R8);
            `BCR_OP_XOR: alu_res = rd_loc(alu_src) ^ rd_loc(`BCR_LOC_R8);
            default:     alu_res = rd_loc(alu_src);
        endcase
    end

    // Read data and error answer decided at the access phase
    always @* begin
        rd_d  = 32'h0000_0000;
        err_d = 1'b0;
        if (is_loc) begin
            rd_d = {24'h00_0000, rd_loc(loc)};
            err_d = pwrite & ~loc_ok(loc);
        end else if (is_bank) begin
            rd_d = {30'h0, alt_b_q, alt_a_q};
            err_d = pwrite;
        end else if (is_imm) begin
            err_d = ~pwrite | (imm_loc >= `BCR_IMM_LIMIT)
                  | ~loc_ok(imm_loc);
        end else if (is_alu) begin
            err_d = ~pwrite | ~loc_ok(alu_dst);
        end else if (is_exch) begin
            err_d = ~pwrite;
        end else begin
            err_d = 1'b1;                                           // Unmapped offset
        end
    end

    // Single write port for locations, taken at the committing edge
    always @* begin
        wr_en  = 1'b0;
        wr_loc = loc;
        wr_val = pwdata[7:0];
        if (commit && pwrite && !pslverr) begin
            if (is_loc) begin
                wr_en = 1'b1;
            end else if (is_imm) begin
                wr_en  = 1'b1;
                wr_loc = imm_loc;
            end else if (is_alu) begin
                wr_en  = 1'b1;
                wr_loc = alu_dst;
                wr_val = alu_res;
            end
        end
    end

    // APB handshake; exchange holds the access phase for two cycles
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            prdata     <= 32'h0000_0000;
            wait_cnt_q <= 2'h0;
        end else if (setup_ok) begin
            if (is_exch && (wait_cnt_q + 2'h1 < `BCR_EXCH_CYCLES)) begin
                wait_cnt_q <= wait_cnt_q + 2'h1;
            end else begin
                pready     <= 1'b1;
                pslverr    <= err_d;
                prdata     <= pwrite ? 32'h0000_0000 : rd_d;
                wait_cnt_q <= 2'h0;
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Bank selection; effective for the very next access
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_a_q <= 1'b1;
            alt_b_q <= 1'b1;
        end else if (commit && pwrite && is_exch && !pslverr) begin
            alt_a_q <= pwdata[`BCR_EX_ALT_A];
            alt_b_q <= pwdata[`BCR_EX_ALT_B];
        end
    end

    // Control and configuration registers in bank A
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            device_control_reg_q <= `BCR_DCR_RESET;
            aux_control_reg_q    <= `BCR_ACR_RESET;
            irq_mask_reg_q       <= `BCR_IMR_RESET;
            vector_base_reg_q    <= `BCR_VBR_RESET;
            cfg_a_q[0]           <= 8'h00;
            cfg_a_q[1]           <= 8'h00;
        end else begin
            if (wr_en && (wr_loc <= `BCR_LOC_R3)) begin
                if (alt_a_q) begin
                    case (wr_loc[1:0])
                        2'h0:    device_control_reg_q <= wr_val;
                        2'h1:    vector_base_reg_q <= wr_val;
                        default: cfg_a_q[wr_loc[0]] <= wr_val;
                    endcase
                end else if (wr_loc[1:0] == 2'h2) begin
                    irq_mask_reg_q <= wr_val;
                end else if (wr_loc[1:0] == 2'h3) begin
                    aux_control_reg_q <= wr_val;
                end
            end
            // Exchange may also switch the global enable
            if (commit && pwrite && is_exch && !pslverr && pwdata[`BCR_EX_IRQ_CHG])
                aux_control_reg_q[`BCR_ACR_GIE] <= pwdata[`BCR_EX_IRQ_VAL];
        end
    end

    // General storage and transceiver access registers in bank B and high range
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < 8; i = i + 1) begin
                main_b_q[i] <= 8'h00;
                gen_hi_q[i] <= 8'h00;
            end
            for (i = 0; i < 4; i = i + 1) begin
                alt_b_q_mem[i] <= 8'h00;
                xacc_q[i]      <= 8'h00;
            end
            xcvr_acc_wr_q   <= 1'b0;
            xcvr_acc_idx_q  <= 2'h0;
            xcvr_acc_data_q <= 8'h00;
        end else begin
            xcvr_acc_wr_q <= 1'b0;
            if (wr_en && (wr_loc >= `BCR_LOC_R4) && (wr_loc <= `BCR_LOC_R11)) begin
                if (!alt_b_q) begin
                    main_b_q[wr_loc[2:0] - 3'h4] <= wr_val;
                end else if (wr_loc < `BCR_LOC_R8) begin
                    xacc_q[wr_loc[1:0]] <= wr_val;
                    xcvr_acc_wr_q       <= 1'b1;
                    xcvr_acc_idx_q      <= wr_loc[1:0];
                    xcvr_acc_data_q     <= wr_val;
                end else begin
                    alt_b_q_mem[wr_loc[1:0]] <= wr_val;
                end
            end else if (wr_en && (wr_loc >= `BCR_LOC_R20) && (wr_loc <= `BCR_LOC_R27)) begin
                gen_hi_q[wr_loc[2:0] - 3'h4] <= wr_val;
            end
        end
    end

    // Wait-state selects follow the device control fields
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_wait_select_q <= 2'h3;
            data_wait_select_q  <= 3'h7;
        end else begin
            instr_wait_select_q <= device_control_reg_q[`BCR_DCR_IW_HI:`BCR_DCR_IW_LO];
            data_wait_select_q  <= device_control_reg_q[`BCR_DCR_DW_HI:`BCR_DCR_DW_LO];
        end
    end

    // Interrupt gating, vector formation and the bidirectional pin
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_active_q   <= 5'h00;
            vector_addr_q  <= 16'h0000;
            bidir_irq_n_o  <= 1'b1;
            bidir_irq_n_oe <= 1'b0;
        end else begin
            // Pin level counts only while the pad is released, so our own drive never loops back
            irq_active_q <= {irq_req[4], ~bidir_irq_n_oe ? ~bidir_irq_n_i : 1'b0, irq_req[2:0]}
                          & irq_mask_reg_q[4:0] & {5{global_irq_enable}};
            vector_addr_q <= {vector_base_reg_q, nmi_take ? `BCR_NMI_VEC_LOW : vec_low};
            bidir_irq_n_oe <= ~pin_input;
            bidir_irq_n_o  <= ~irq_mask_reg_q[`BCR_IRQ_THREE];
        end
    end

    // Host-only control register; no APB path reaches it and it never stalls APB
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            host_side_control_reg_q <= `BCR_HOST_RESET;
        else if (host_wr)
            host_side_control_reg_q <= host_wdata;
    end

    // Clock selection and output enable
    bcr_clk_ctl u_clk (
        .pclk              (pclk),
        .presetn           (presetn),
        .cpu_clock_select  (device_control_reg_q[`BCR_DCR_CCS]),
        .xcvr_clock_select (device_control_reg_q[`BCR_DCR_TCS_HI:`BCR_DCR_TCS_LO]),
        .clock_out_disable (aux_control_reg_q[`BCR_ACR_COD]),
        .ext_xcvr_clock_in (ext_xcvr_clock_in),
        .cpu_tick_q        (cpu_tick_q),
        .xcvr_tick_q       (xcvr_tick_q),
        .clock_out_oe_q    (clock_out_oe_q)
    );
endmodule
